// >>> pkg/tccc_defines.vh
/*
  Register indices, field positions and reset values of the two-channel
  capture/compare block.
  Assumes a 32-bit Avalon-MM slave with word addressing; each register
  occupies the low byte of one word.
*/
`ifndef TCCC_DEFINES_VH
`define TCCC_DEFINES_VH

// word indices on AVS_ADDRESS
`define TCCC_IDX_SC0      3'h0
`define TCCC_IDX_SC1      3'h1
`define TCCC_IDX_CH0H     3'h2
`define TCCC_IDX_CH0L     3'h3
`define TCCC_IDX_CH1H     3'h4
`define TCCC_IDX_CH1L     3'h5

// channel status/control fields
`define TCCC_BIT_FLAG     7
`define TCCC_BIT_IE       6
`define TCCC_BIT_MSB      5
`define TCCC_BIT_MSA      4
`define TCCC_BIT_ELSB     3
`define TCCC_BIT_ELSA     2
`define TCCC_BIT_TOV      1
`define TCCC_BIT_MAX      0

// edge/level codes
`define TCCC_ELS_NONE     2'h0
`define TCCC_ELS_TOGGLE   2'h1
`define TCCC_ELS_CLEAR    2'h2
`define TCCC_ELS_SET      2'h3

// reset values
`define TCCC_CTL_RST      7'h00
`define TCCC_RDATA_RST    32'h00000000

`endif

// >>> hw/tccc_top.v
/*
  Two-channel input capture / output compare / PWM logic for a free-running
  16-bit timer counter, with channel registers on an Avalon-MM slave.
  Assumes the counter, prescaler and modulo compare live outside on the same
  clock; CNT_VALUE, CNT_OVF, CNT_STOP and DBG_BREAK come from that logic.
  Channel pins come from outside and are synchronised here.
*/
`timescale 1ns/100ps
`include "tccc_defines.vh"

module tccc_top (
  // clock and reset
  input  wire        CLK,
  input  wire        RSTN,
  // avalon-mm slave
  input  wire [2:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [3:0]  AVS_BYTEENABLE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  // timer counter side
  input  wire [15:0] CNT_VALUE,
  input  wire        CNT_OVF,
  input  wire        CNT_STOP,
  input  wire        DBG_BREAK,
  output reg         CNT_HOLD,
  // channel pins
  input  wire [1:0]  CHAN_PIN_I,
  output reg  [1:0]  CHAN_PIN_O,
  output reg  [1:0]  CHAN_PIN_OE,
  // interrupt requests
  output reg  [1:0]  CHAN_IRQ
);

  reg  [6:0]  ctl_r [0:1];
  reg  [15:0] val_r [0:1];
  reg  [1:0]  flag_r;
  reg  [1:0]  arm_r;
  reg  [1:0]  caplk_r;
  reg  [1:0]  cmplk_r;
  reg  [1:0]  maxon_r;
  reg  [1:0]  sync1_r;
  reg  [1:0]  sync2_r;
  reg  [1:0]  prev_r;
  reg         buf_sel_r;

  wire        req;
  wire        acc;
  wire        wr;
  wire        rd;
  wire        buf_on;

  // status/control index of a channel
  function [2:0] sc_idx;
    input ch;
    begin
      sc_idx = ch ? `TCCC_IDX_SC1 : `TCCC_IDX_SC0;
    end
  endfunction

  // high byte index of a channel value
  function [2:0] hi_idx;
    input ch;
    begin
      hi_idx = ch ? `TCCC_IDX_CH1H : `TCCC_IDX_CH0H;
    end
  endfunction

  // low byte index of a channel value
  function [2:0] lo_idx;
    input ch;
    begin
      lo_idx = ch ? `TCCC_IDX_CH1L : `TCCC_IDX_CH0L;
    end
  endfunction

  // read mux; unmapped words read as zero
  function [7:0] rd_byte;
    input [2:0]  a;
    input [1:0]  f;
    input [6:0]  c0;
    input [6:0]  c1;
    input [15:0] v0;
    input [15:0] v1;
    begin
      case (a)
        `TCCC_IDX_SC0:  rd_byte = {f[0], c0};
        `TCCC_IDX_SC1:  rd_byte = {f[1], c1};
        `TCCC_IDX_CH0H: rd_byte = v0[15:8];
        `TCCC_IDX_CH0L: rd_byte = v0[7:0];
        `TCCC_IDX_CH1H: rd_byte = v1[15:8];
        `TCCC_IDX_CH1L: rd_byte = v1[7:0];
        default:        rd_byte = 8'h00;
      endcase
    end
  endfunction

  // one wait cycle per access: data are fetched while waitrequest is high,
  // side effects happen on the edge that releases the master
  assign req    = AVS_READ | AVS_WRITE;
  assign acc    = req & ~AVS_WAITREQUEST;
  assign wr     = acc & AVS_WRITE & AVS_BYTEENABLE[0];
  assign rd     = acc & AVS_READ;
  assign buf_on = ctl_r[0][`TCCC_BIT_MSB];

  always @(posedge CLK) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= `TCCC_RDATA_RST;
    end else begin
      if (req && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
        // read data stand until the next read, writes leave them alone
        if (AVS_READ)
          AVS_READDATA <= {24'h000000,
                           rd_byte(AVS_ADDRESS, flag_r, ctl_r[0], ctl_r[1], val_r[0], val_r[1])};
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
    end
  end

  // pin synchronisers; first stage feeds only the second
  always @(posedge CLK) begin
    if (!RSTN) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      prev_r  <= 2'h0;
    end else begin
      sync1_r <= CHAN_PIN_I;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // buffered compare register select and counter hold
  always @(posedge CLK) begin
    if (!RSTN) begin
      buf_sel_r <= 1'b0;
      CNT_HOLD  <= 1'b0;
    end else begin
      CNT_HOLD <= DBG_BREAK;
      if (!buf_on)
        buf_sel_r <= 1'b0;
      else if (CNT_OVF)
        buf_sel_r <= ~buf_sel_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_chan
      localparam [0:0] CH = i;
      wire        off;
      wire        msa;
      wire        msb;
      wire [1:0]  els;
      wire        tov;
      wire        cap;
      wire        cmp;
      wire [15:0] cval;
      wire        lk;
      wire        match;
      wire        rise;
      wire        fall;
      wire        hit;
      wire        capev;
      wire        ev;
      wire        scw;
      wire        scr;
      wire        hiw;
      wire        low;
      wire        hir;
      wire        lor;

      // channel 1 goes dead while channel 0 runs buffered
      assign off   = (i == 1) && buf_on;
      assign msa   = ctl_r[i][`TCCC_BIT_MSA];
      assign msb   = (i == 0) && buf_on;
      assign els   = off ? `TCCC_ELS_NONE : ctl_r[i][`TCCC_BIT_ELSB:`TCCC_BIT_ELSA];
      assign tov   = ctl_r[i][`TCCC_BIT_TOV];
      assign cap   = ~off & ~msa & ~msb & (els != `TCCC_ELS_NONE);
      assign cmp   = ~off & (msa | msb);
      assign cval  = msb ? (buf_sel_r ? val_r[1] : val_r[0]) : val_r[i];
      // in buffered mode a half-written channel 1 value also holds off matches
      assign lk    = cmplk_r[i] | (msb & cmplk_r[1]);
      assign match = cmp & ~lk & (CNT_VALUE == cval);
      assign rise  = sync2_r[i] & ~prev_r[i];
      assign fall  = ~sync2_r[i] & prev_r[i];
      assign hit   = (els[0] & rise) | (els[1] & fall);
      assign capev = cap & hit & ~caplk_r[i] & ~CNT_STOP & ~DBG_BREAK;
      assign ev    = capev | match;
      assign scw   = wr & (AVS_ADDRESS == sc_idx(CH));
      assign scr   = rd & (AVS_ADDRESS == sc_idx(CH));
      assign hiw   = wr & (AVS_ADDRESS == hi_idx(CH));
      assign low   = wr & (AVS_ADDRESS == lo_idx(CH));
      assign hir   = rd & (AVS_ADDRESS == hi_idx(CH));
      assign lor   = rd & (AVS_ADDRESS == lo_idx(CH));

      // control and flag
      always @(posedge CLK) begin
        if (!RSTN) begin
          ctl_r[i]  <= `TCCC_CTL_RST;
          flag_r[i] <= 1'b0;
          arm_r[i]  <= 1'b0;
        end else begin
          if (scw && !off)
            ctl_r[i] <= {AVS_WRITEDATA[`TCCC_BIT_IE],
                         (i == 0) ? AVS_WRITEDATA[`TCCC_BIT_MSB] : 1'b0,
                         AVS_WRITEDATA[`TCCC_BIT_MSA:`TCCC_BIT_MAX]};
          // an event wins over a pending clear
          if (ev)
            flag_r[i] <= 1'b1;
          else if (scw && !off && arm_r[i] && !AVS_WRITEDATA[`TCCC_BIT_FLAG])
            flag_r[i] <= 1'b0;
          // arm only if the value handed to software showed the flag set
          if (ev || scw)
            arm_r[i] <= 1'b0;
          else if (scr && AVS_READDATA[`TCCC_BIT_FLAG])
            arm_r[i] <= 1'b1;
        end
      end

      // value register and byte interlocks; value itself has no reset
      always @(posedge CLK) begin
        if (capev)
          val_r[i] <= CNT_VALUE;
        else if (hiw)
          val_r[i][15:8] <= AVS_WRITEDATA[7:0];
        else if (low)
          val_r[i][7:0] <= AVS_WRITEDATA[7:0];
      end

      always @(posedge CLK) begin
        if (!RSTN) begin
          caplk_r[i] <= 1'b0;
          cmplk_r[i] <= 1'b0;
        end else begin
          if (lor)
            caplk_r[i] <= 1'b0;
          else if (hir && !msa && !msb)
            caplk_r[i] <= 1'b1;
          if (low)
            cmplk_r[i] <= 1'b0;
          else if (hiw && (msa || msb || (i == 1 && buf_on)))
            cmplk_r[i] <= 1'b1;
        end
      end

      // pin output, full-duty latch and interrupt request
      always @(posedge CLK) begin
        if (!RSTN) begin
          CHAN_PIN_O[i]  <= 1'b1;
          CHAN_PIN_OE[i] <= 1'b0;
          maxon_r[i]     <= 1'b0;
          CHAN_IRQ[i]    <= 1'b0;
        end else begin
          CHAN_IRQ[i]    <= flag_r[i] & ctl_r[i][`TCCC_BIT_IE];
          CHAN_PIN_OE[i] <= cmp & (els != `TCCC_ELS_NONE);
          // full duty is sampled only at the PWM cycle boundary
          if (!cmp)
            maxon_r[i] <= 1'b0;
          else if (CNT_OVF)
            maxon_r[i] <= ctl_r[i][`TCCC_BIT_MAX] & tov;
          if (els == `TCCC_ELS_NONE)
            CHAN_PIN_O[i] <= ~msa;
          else if (cmp) begin
            if (maxon_r[i] && !(CNT_OVF && !(ctl_r[i][`TCCC_BIT_MAX] & tov)))
              CHAN_PIN_O[i] <= 1'b1;
            else if (CNT_OVF && tov)
              CHAN_PIN_O[i] <= ~CHAN_PIN_O[i];
            else if (match) begin
              case (els)
                `TCCC_ELS_TOGGLE: CHAN_PIN_O[i] <= ~CHAN_PIN_O[i];
                `TCCC_ELS_CLEAR:  CHAN_PIN_O[i] <= 1'b0;
                `TCCC_ELS_SET:    CHAN_PIN_O[i] <= 1'b1;
                default:          CHAN_PIN_O[i] <= CHAN_PIN_O[i];
              endcase
            end
          end
        end
      end
    end
  endgenerate

endmodule // tccc_top

// >>> testbench/tccc_props.sv
/* checker for tccc_top: bus handshake, read data, pin enables, request release
   assumes it is bound to tccc_top and sees only its ports */
`timescale 1ns/100ps
module tccc_props (
  // clock and reset
  input wire        CLK,
  input wire        RSTN,
  // register bus
  input wire [2:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [3:0]  AVS_BYTEENABLE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  // counter side
  input wire [15:0] CNT_VALUE,
  input wire        CNT_OVF,
  input wire        CNT_STOP,
  input wire        DBG_BREAK,
  input wire        CNT_HOLD,
  // pins and requests
  input wire [1:0]  CHAN_PIN_I,
  input wire [1:0]  CHAN_PIN_O,
  input wire [1:0]  CHAN_PIN_OE,
  input wire [1:0]  CHAN_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  hold_follows_break_a: assert property ($past(RSTN) |-> CNT_HOLD == $past(DBG_BREAK))
    else $error("hold does not follow break");
  wait_one_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low for more than one cycle");
  wait_idle_a: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("answer without request");
  rdata_stand_a: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
    else $error("read data moved without a read");
  upper_zero_a: assert property (AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  unmapped_zero_a: assert property (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS[2:1] == 2'h3 |=> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  irq_release_a: assert property ($fell(CHAN_IRQ[0]) || $fell(CHAN_IRQ[1]) |-> $past(AVS_WRITE && !AVS_WAITREQUEST, 2))
    else $error("request dropped without a write");
  oe_by_write_a: assert property ($changed(CHAN_PIN_OE) |-> $past(AVS_WRITE && !AVS_WAITREQUEST) || $past(AVS_WRITE && !AVS_WAITREQUEST, 2))
    else $error("pin enable moved without a write");
endmodule // tccc_props

bind tccc_top tccc_props tccc_props_inst (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CNT_VALUE(CNT_VALUE), .CNT_OVF(CNT_OVF), .CNT_STOP(CNT_STOP),
  .DBG_BREAK(DBG_BREAK), .CNT_HOLD(CNT_HOLD), .CHAN_PIN_I(CHAN_PIN_I), .CHAN_PIN_O(CHAN_PIN_O),
  .CHAN_PIN_OE(CHAN_PIN_OE), .CHAN_IRQ(CHAN_IRQ));

// >>> testbench/tccc_tb_top.sv
/* self-checking bench for tccc_top: compare actions, flag clearing, capture edges, blocking, buffered mode
   assumes the checker binds itself from its own file */
`timescale 1ns/100ps
`include "tccc_defines.vh"
module tccc_tb_top;
  // clock, reset and bus
  logic        CLK = 1'h0;
  logic        RSTN = 1'h0;
  logic [2:0]  AVS_ADDRESS = 3'h0;
  logic        AVS_READ = 1'h0;
  logic        AVS_WRITE = 1'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  // counter side and pins
  logic [15:0] CNT_VALUE = 16'h0;
  logic        CNT_OVF = 1'h0;
  logic        CNT_STOP = 1'h0;
  logic        DBG_BREAK = 1'h0;
  logic        CNT_HOLD;
  logic [1:0]  CHAN_PIN_I = 2'h0;
  logic [1:0]  CHAN_PIN_O;
  logic [1:0]  CHAN_PIN_OE;
  logic [1:0]  CHAN_IRQ;
  int          fail_count = 0;
  int          checks = 0;
  logic [15:0] v;
  logic [7:0]  q;
  logic        p;
  always #5 CLK = ~CLK;
  tccc_top tccc_top_inst (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CNT_VALUE(CNT_VALUE), .CNT_OVF(CNT_OVF), .CNT_STOP(CNT_STOP),
    .DBG_BREAK(DBG_BREAK), .CNT_HOLD(CNT_HOLD), .CHAN_PIN_I(CHAN_PIN_I), .CHAN_PIN_O(CHAN_PIN_O),
    .CHAN_PIN_OE(CHAN_PIN_OE), .CHAN_IRQ(CHAN_IRQ));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access; read data taken at the edge where wait is seen low
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'h0 && n < 64);
    q = AVS_READDATA[7:0];
    AVS_READ <= 1'h0;
    AVS_WRITE <= 1'h0;
    if (n >= 64) fail_count++;
  endtask
  task automatic hit(input logic ovf);
    @(posedge CLK);
    CNT_VALUE <= v;
    CNT_OVF <= ovf;
    @(posedge CLK);
    CNT_VALUE <= ~v;
    CNT_OVF <= 1'h0;
    repeat (2) @(posedge CLK);
  endtask
  function automatic logic exp_pin(input int e, input logic prev);
    return (e == 1) ? !prev : (e == 3);
  endfunction
  task test_done;
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    test_done;
  end
  initial begin
    void'($urandom(32'hC13E));
    repeat (16) @(posedge CLK);
    RSTN <= 1'h1;
    @(posedge CLK);
    chk("pin_o", CHAN_PIN_O, 2'h3);
    chk("pin_oe", CHAN_PIN_OE, 2'h0);
    bus(1'h0, `TCCC_IDX_SC0, 8'h0);
    chk("sc0", q, 8'h0);
    for (int e = 0; e < 4; e++) begin
      v = $urandom;
      CNT_VALUE <= ~v;
      bus(1'h1, `TCCC_IDX_SC0, {4'h5, e[1:0], 2'h0});
      bus(1'h1, `TCCC_IDX_CH0H, v[15:8]);
      bus(1'h1, `TCCC_IDX_CH0L, v[7:0]);
      p = CHAN_PIN_O[0];
      hit(1'h0);
      chk("pin0", CHAN_PIN_O[0], exp_pin(e, p));
      chk("irq0", CHAN_IRQ[0], 1'h1);
      bus(1'h0, `TCCC_IDX_SC0, 8'h0);
      chk("flag0", q[7], 1'h1);
      bus(1'h1, `TCCC_IDX_SC0, {4'hD, e[1:0], 2'h0});
      bus(1'h1, `TCCC_IDX_SC0, {4'h5, e[1:0], 2'h0});
      bus(1'h0, `TCCC_IDX_SC0, 8'h0);
      chk("flag_kept", q[7], 1'h1);
      bus(1'h1, `TCCC_IDX_SC0, {4'h5, e[1:0], 2'h0});
      repeat (2) @(posedge CLK);
      chk("irq0_clr", CHAN_IRQ[0], 1'h0);
    end
    bus(1'h1, `TCCC_IDX_SC0, 8'h5E);
    hit(1'h1);
    chk("pin0_ovf", CHAN_PIN_O[0], 1'h0);
    for (int e = 1; e < 4; e++) begin
      for (int k = 0; k < 2; k++) begin
        bus(1'h0, `TCCC_IDX_SC1, 8'h0);
        bus(1'h1, `TCCC_IDX_SC1, {4'h0, e[1:0], 2'h0});
        v = $urandom;
        CNT_VALUE <= v;
        CHAN_PIN_I[1] <= !k[0];
        repeat (6) @(posedge CLK);
        bus(1'h0, `TCCC_IDX_SC1, 8'h0);
        chk("cap_flag", q[7], e[k]);
        if (e[k]) begin
          bus(1'h0, `TCCC_IDX_CH1H, 8'h0);
          chk("cap_hi", q, v[15:8]);
          bus(1'h0, `TCCC_IDX_CH1L, 8'h0);
          chk("cap_lo", q, v[7:0]);
        end
      end
    end
    bus(1'h0, `TCCC_IDX_SC1, 8'h0);
    bus(1'h1, `TCCC_IDX_SC1, 8'h0C);
    for (int i = 0; i < 2; i++) begin
      CNT_STOP <= (i == 0);
      DBG_BREAK <= (i == 1);
      CHAN_PIN_I[1] <= !CHAN_PIN_I[1];
      repeat (6) @(posedge CLK);
      chk("hold", CNT_HOLD, DBG_BREAK);
      bus(1'h0, `TCCC_IDX_SC1, 8'h0);
      chk("blocked", q[7], 1'h0);
    end
    DBG_BREAK <= 1'h0;
    CNT_STOP <= 1'h1;
    bus(1'h1, `TCCC_IDX_SC1, 8'h54);
    bus(1'h1, `TCCC_IDX_SC0, 8'h24);
    bus(1'h1, `TCCC_IDX_SC1, 8'h48);
    bus(1'h0, `TCCC_IDX_SC1, 8'h0);
    chk("sc1_buf", q[6:0], 7'h54);
    chk("oe1_buf", CHAN_PIN_OE[1], 1'h0);
    CNT_STOP <= 1'h0;
    bus(1'h1, `TCCC_IDX_SC0, 8'h27);
    hit(1'h1);
    chk("pin0_max", CHAN_PIN_O[0], 1'h1);
    hit(1'h1);
    chk("pin0_max2", CHAN_PIN_O[0], 1'h1);
    bus(1'h0, 3'h7, 8'h0);
    chk("unmapped", q, 8'h0);
    test_done;
  end
endmodule // tccc_tb_top
